// ==== design/smr_responder.sv ====
/*
  Sensor-side responder for measurement, concurrent and send-data commands.
  Assumes received characters arrive as one-cycle strobes synchronous to
  clk_sys_i and that the line sender drains tx bytes with a ready handshake.
*/
`timescale 1ns/1ps
`include "smr_consts.svh"

// What this block does
// - Combined variant: data request 0 after a measurement gives filtered level, filtered velocity, both SNRs and discharge.
// - A three-character CRC precedes CR LF on data replies only after a CRC-requesting start.
// - Combined variant: after additional measurement 1, data request 0 gives current level and current distance.
// - Combined variant: after a concurrent start, data request 1 gives the level, velocity and discharge quality flags.
// - Combined variant: after additional measurement 2, data request 0 gives temperature, tilt x and tilt y.
// - Combined variant: after a concurrent start, data request 2 gives the sensor height above reference.
// - Data requests with nothing behind them answer with address and terminator, plus CRC if asked.
// - Velocity variant: a measurement start is acknowledged with wait time and a count of four.
// - The announced wait is the filter length, capped at 999, until a reading exists, then zero.
// - A service request is sent when data is ready or when the wait runs out, and never for a zero wait.
// - Velocity variant: additional measurement 1 announces four values, 2 and up announce zero.
// - Velocity variant: a concurrent start announces 08 values and sends no service request.
module smr_responder #(
  parameter int unsigned TICK_CYCLES = `SMR_SEC_NS / `SMR_CLK_NS
) (
  input wire logic clk_sys_i,              // System clock, 50 MHz
  input wire logic rst_n_i,                // Asynchronous reset, low active
  input wire logic rx_valid_i,             // Received character strobe
  input wire logic [7:0] rx_data_i,        // Received character
  input wire logic [7:0] addr_i,           // Own address character
  input wire logic velocity_i,             // High: velocity-only variant
  input wire logic data_valid_i,           // A filtered reading exists
  input wire logic [9:0] filter_len_s_i,   // Filter length in seconds
  input wire logic [15:0][19:0] vals_i,    // Signed values by slot
  input wire logic tx_ready_i,             // Line sender takes a byte
  output logic tx_valid_o,                 // Byte to send is present
  output logic [7:0] tx_data_o             // Byte to send
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  smr_pkg::smr_pstate_t ps_q, ps_d;
  logic [7:0] cmd_q, cmd_d;
  logic gotc_q, gotc_d, hasdig_q, hasdig_d;
  logic [3:0] dig_q, dig_d;
  logic go;
  logic [7:0] cmd_now;
  smr_pkg::smr_tstate_t st_q, st_d;
  smr_pkg::smr_job_t job_q, job_d;
  smr_pkg::smr_meas_t meas_q, meas_d, mk_c;
  logic [2:0] d_q, d_d, k_q, k_d, dsel;
  logic [23:0] map_q, map_d;
  logic [15:0] crc_q, crc_d;
  logic [19:0] val_q, val_d, vsel;
  logic [9:0] ttt_q, ttt_d, sec_q, sec_d, ttt_c;
  logic [3:0] cnt_q, cnt_d, slot, dig_c;
  logic two_q, two_d, crc_en_q, crc_en_d, sr_pend_q, sr_pend_d;
  logic [25:0] tick_q, tick_d;
  logic [7:0] byte_c;
  logic push, sr_fire;
  logic [23:0] bcd;
  smr_byte_if bs ();

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `SMR_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_upd

  // Which value slots a data request returns, by start type and index
  function automatic logic [23:0] data_map(input smr_pkg::smr_meas_t mk, input logic vel,
                                           input logic [3:0] idx);
    data_map = `SMR_MAP_NONE;
    case (mk)
      smr_pkg::MK_M0: if (idx == 4'h0) data_map = vel ? `SMR_MAP_VEL_D0 : `SMR_MAP_COMB_D0;
      smr_pkg::MK_M1: if (idx == 4'h0) data_map = vel ? `SMR_MAP_VEL_M1 : `SMR_MAP_COMB_M1;
      smr_pkg::MK_M2: if (idx == 4'h0 && !vel) data_map = `SMR_MAP_COMB_M2;
      smr_pkg::MK_C: begin
        if (idx == 4'h0) data_map = vel ? `SMR_MAP_VEL_D0 : `SMR_MAP_COMB_D0;
        else if (idx == 4'h1) data_map = vel ? `SMR_MAP_VEL_M1 : `SMR_MAP_COMB_C1;
        else if (idx == 4'h2 && !vel) data_map = `SMR_MAP_COMB_C2;
      end
      default: data_map = `SMR_MAP_NONE;
    endcase
  endfunction : data_map

  // Announced count; a standard start stays at nine or below
  function automatic logic [3:0] ack_count(input smr_pkg::smr_meas_t mk, input logic vel);
    case (mk)
      smr_pkg::MK_M0: ack_count = vel ? `SMR_N_VEL_M : `SMR_N_COMB_M;
      smr_pkg::MK_M1: ack_count = vel ? `SMR_N_VEL_M1 : `SMR_N_COMB_M1;
      smr_pkg::MK_M2: ack_count = vel ? `SMR_N_NONE : `SMR_N_COMB_M2;
      smr_pkg::MK_C: ack_count = vel ? `SMR_N_VEL_C : `SMR_N_COMB_C;
      default: ack_count = `SMR_N_NONE;
    endcase
  endfunction : ack_count

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Command parser: address, then '!' alone or M/C/D; optional C on M/C, digit optional on M and required on D, then '!'
  always_comb begin
    ps_d = ps_q;
    cmd_d = cmd_q;
    gotc_d = gotc_q;
    hasdig_d = hasdig_q;
    dig_d = dig_q;
    go = 1'b0;
    cmd_now = (ps_q == smr_pkg::P_CMD) ? 8'h00 : cmd_q;
    if (rx_valid_i) begin
      case (ps_q)
        smr_pkg::P_IDLE: if (rx_data_i == addr_i) ps_d = smr_pkg::P_CMD;
        smr_pkg::P_CMD: begin
          gotc_d = 1'b0;
          hasdig_d = 1'b0;
          dig_d = 4'h0;
          cmd_d = rx_data_i;
          ps_d = smr_pkg::P_IDLE;
          if (rx_data_i == `SMR_CH_BANG) go = 1'b1;
          else if (rx_data_i == `SMR_CH_M || rx_data_i == `SMR_CH_C ||
                   rx_data_i == `SMR_CH_D) ps_d = smr_pkg::P_BODY;
        end
        smr_pkg::P_BODY: begin
          ps_d = smr_pkg::P_IDLE;
          if (rx_data_i == `SMR_CH_BANG) begin
            go = (cmd_q != `SMR_CH_D) || hasdig_q;
          end else if (rx_data_i == `SMR_CH_C && cmd_q != `SMR_CH_D && !gotc_q && !hasdig_q) begin
            gotc_d = 1'b1;
            ps_d = smr_pkg::P_BODY;
          end else if (rx_data_i >= `SMR_CH_ZERO && rx_data_i <= `SMR_CH_NINE &&
                       cmd_q != `SMR_CH_C && !hasdig_q) begin
            dig_d = rx_data_i[3:0];
            hasdig_d = 1'b1;
            ps_d = smr_pkg::P_BODY;
          end
        end
        default: ps_d = smr_pkg::P_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ps_q <= smr_pkg::P_IDLE;
      cmd_q <= 8'h00;
      gotc_q <= 1'b0;
      hasdig_q <= 1'b0;
      dig_q <= 4'h0;
    end else begin
      ps_q <= ps_d;
      cmd_q <= cmd_d;
      gotc_q <= gotc_d;
      hasdig_q <= hasdig_d;
      dig_q <= dig_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Response sequencer and service-request timer
  assign push = (st_q != smr_pkg::S_IDLE) && bs.ready;
  assign slot = map_q[{k_q, 2'b00} +: 4];
  assign vsel = vals_i[slot];
  assign dsel = (st_q == smr_pkg::S_TTT) ? 3'h2 - d_q : 3'h5 - d_q;
  assign dig_c = bcd[{dsel, 2'b00} +: 4];
  assign ttt_c = data_valid_i ? 10'h000 :
                 (filter_len_s_i > `SMR_TTT_MAX ? `SMR_TTT_MAX : filter_len_s_i);
  assign mk_c = !hasdig_q ? smr_pkg::MK_M0 : (dig_q == 4'h1) ? smr_pkg::MK_M1 :
                (dig_q == 4'h2) ? smr_pkg::MK_M2 : (dig_q == 4'h0) ? smr_pkg::MK_M0 :
                smr_pkg::MK_MX;
  // The deadline sends the request even if no reading showed up in time
  assign sr_fire = sr_pend_q && (data_valid_i || sec_q >= ttt_q) && !go;

  always_comb begin
    st_d = st_q;
    job_d = job_q;
    d_d = d_q;
    k_d = k_q;
    map_d = map_q;
    crc_d = crc_q;
    val_d = val_q;
    ttt_d = ttt_q;
    cnt_d = cnt_q;
    two_d = two_q;
    meas_d = meas_q;
    crc_en_d = crc_en_q;
    sr_pend_d = sr_pend_q;
    sec_d = sec_q;
    tick_d = tick_q;
    byte_c = 8'h00;
    // One-second ticks while a service request is owed
    if (sr_pend_q) begin
      tick_d = (tick_q == 26'(TICK_CYCLES - 1)) ? 26'h0000000 : tick_q + 26'h0000001;
      if (tick_q == 26'(TICK_CYCLES - 1)) sec_d = sec_q + 10'h001;
    end
    case (st_q)
      smr_pkg::S_IDLE: begin
        d_d = 3'h0;
        k_d = 3'h0;
        crc_d = `SMR_CRC_INIT;
        if (go) begin
          st_d = smr_pkg::S_ADDR;
          job_d = smr_pkg::J_ADDR;
          if (cmd_now == `SMR_CH_M || cmd_now == `SMR_CH_C) begin
            job_d = smr_pkg::J_ACK;
            meas_d = (cmd_now == `SMR_CH_C) ? smr_pkg::MK_C : mk_c;
            crc_en_d = gotc_q;
            ttt_d = ttt_c;
            two_d = (cmd_now == `SMR_CH_C);
            cnt_d = ack_count(meas_d, velocity_i);
            // Concurrent starts owe no request, nor does a zero wait
            sr_pend_d = (cmd_now == `SMR_CH_M) && (ttt_c != 10'h000);
            sec_d = 10'h000;
            tick_d = 26'h0000000;
          end else if (cmd_now == `SMR_CH_D) begin
            job_d = smr_pkg::J_DATA;
            map_d = data_map(meas_q, velocity_i, dig_q);
          end
        end else if (sr_fire) begin
          st_d = smr_pkg::S_ADDR;
          job_d = smr_pkg::J_SREQ;
          sr_pend_d = 1'b0;
        end
      end
      smr_pkg::S_ADDR: begin
        byte_c = addr_i;
        if (push) begin
          crc_d = crc_upd(crc_q, byte_c);
          if (job_q == smr_pkg::J_ACK) st_d = smr_pkg::S_TTT;
          else if (job_q != smr_pkg::J_DATA) st_d = smr_pkg::S_CR;
          else if (map_q[23:20] != 4'h0) st_d = smr_pkg::S_SIGN;
          else st_d = crc_en_q ? smr_pkg::S_CRC : smr_pkg::S_CR;
        end
      end
      smr_pkg::S_TTT: begin
        byte_c = `SMR_CH_ZERO | {4'h0, dig_c};
        if (push) begin
          d_d = (d_q == 3'h2) ? 3'h0 : d_q + 3'h1;
          if (d_q == 3'h2) st_d = smr_pkg::S_CNT;
        end
      end
      smr_pkg::S_CNT: begin
        // Counts stay below ten, so a two-digit count leads with zero
        byte_c = (two_q && d_q == 3'h0) ? `SMR_CH_ZERO : (`SMR_CH_ZERO | {4'h0, cnt_q});
        if (push) begin
          d_d = 3'h1;
          if (!two_q || d_q != 3'h0) st_d = smr_pkg::S_CR;
        end
      end
      smr_pkg::S_SIGN: begin
        byte_c = vsel[19] ? `SMR_CH_MINUS : `SMR_CH_PLUS;
        if (push) begin
          crc_d = crc_upd(crc_q, byte_c);
          val_d = vsel[19] ? (~vsel + 20'h00001) : vsel;
          d_d = 3'h0;
          st_d = smr_pkg::S_DIG;
        end
      end
      smr_pkg::S_DIG: begin
        byte_c = `SMR_CH_ZERO | {4'h0, dig_c};
        if (push) begin
          crc_d = crc_upd(crc_q, byte_c);
          d_d = d_q + 3'h1;
          if (d_q == 3'h5) begin
            d_d = 3'h0;
            k_d = k_q + 3'h1;
            if ({1'b0, k_q} + 4'h1 < map_q[23:20]) st_d = smr_pkg::S_SIGN;
            else st_d = crc_en_q ? smr_pkg::S_CRC : smr_pkg::S_CR;
          end
        end
      end
      smr_pkg::S_CRC: begin
        byte_c = (d_q == 3'h0) ? (`SMR_CRC_BASE | {4'h0, crc_q[15:12]}) :
                 (d_q == 3'h1) ? (`SMR_CRC_BASE | {2'b00, crc_q[11:6]}) :
                 (`SMR_CRC_BASE | {2'b00, crc_q[5:0]});
        if (push) begin
          d_d = d_q + 3'h1;
          if (d_q == 3'h2) st_d = smr_pkg::S_CR;
        end
      end
      smr_pkg::S_CR: begin
        byte_c = `SMR_CH_CR;
        if (push) st_d = smr_pkg::S_LF;
      end
      smr_pkg::S_LF: begin
        byte_c = `SMR_CH_LF;
        if (push) st_d = smr_pkg::S_IDLE;
      end
      default: st_d = smr_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= smr_pkg::S_IDLE;
      job_q <= smr_pkg::J_ADDR;
      meas_q <= smr_pkg::MK_NONE;
      d_q <= 3'h0;
      k_q <= 3'h0;
      map_q <= `SMR_MAP_NONE;
      crc_q <= `SMR_CRC_INIT;
      val_q <= 20'h00000;
      ttt_q <= 10'h000;
      cnt_q <= 4'h0;
      two_q <= 1'b0;
      crc_en_q <= 1'b0;
      sr_pend_q <= 1'b0;
      sec_q <= 10'h000;
      tick_q <= 26'h0000000;
    end else begin
      st_q <= st_d;
      job_q <= job_d;
      meas_q <= meas_d;
      d_q <= d_d;
      k_q <= k_d;
      map_q <= map_d;
      crc_q <= crc_d;
      val_q <= val_d;
      ttt_q <= ttt_d;
      cnt_q <= cnt_d;
      two_q <= two_d;
      crc_en_q <= crc_en_d;
      sr_pend_q <= sr_pend_d;
      sec_q <= sec_d;
      tick_q <= tick_d;
    end
  end

  assign bs.valid = (st_q != smr_pkg::S_IDLE);
  assign bs.data = byte_c;

  smr_bin2bcd #(.IN_W(20), .DIGITS(6)) u_bcd (
    .bin_i((st_q == smr_pkg::S_TTT) ? {10'h000, ttt_q} : val_q),
    .bcd_o(bcd)
  );

  smr_skid_buf #(.WIDTH(8)) u_buf (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n),
    .in_s(bs),
    .out_valid_o(tx_valid_o),
    .out_data_o(tx_data_o),
    .out_ready_i(tx_ready_i)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  // Data request accepted this cycle
  logic dreq_go;
  assign dreq_go = go && st_q == smr_pkg::S_IDLE && cmd_now == `SMR_CH_D;

  comb_d0_map_a: assert property (dreq_go && !velocity_i && meas_q == smr_pkg::MK_M0 &&
    dig_q == 4'h0 |=> map_q == `SMR_MAP_COMB_D0) else $error("combined data 0 map wrong");
  crc_only_req_a: assert property (st_q == smr_pkg::S_CRC |-> crc_en_q &&
    job_q == smr_pkg::J_DATA) else $error("crc sent without request");
  m1_map_a: assert property (dreq_go && !velocity_i && meas_q == smr_pkg::MK_M1 &&
    dig_q == 4'h0 |=> map_q[23:20] == 4'h2 && map_q[3:0] == 4'h5)
    else $error("additional 1 map wrong");
  conc_maps_a: assert property (dreq_go && !velocity_i && meas_q == smr_pkg::MK_C &&
    dig_q == 4'h1 |=> map_q == `SMR_MAP_COMB_C1) else $error("concurrent data 1 map wrong");
  empty_reply_a: assert property (dreq_go && dig_q >= 4'h3 |=>
    map_q[23:20] == 4'h0 && st_q == smr_pkg::S_ADDR)
    else $error("empty data reply carries values");
  vel_counts_a: assert property (go && st_q == smr_pkg::S_IDLE && velocity_i &&
    cmd_now == `SMR_CH_C |=> cnt_q == 4'h8 && two_q && !sr_pend_q)
    else $error("velocity concurrent ack wrong");
  vel_m_count_a: assert property (go && st_q == smr_pkg::S_IDLE && velocity_i &&
    cmd_now == `SMR_CH_M && dig_q < 4'h2 |=> cnt_q == 4'h4)
    else $error("velocity measurement count wrong");
  wait_zero_a: assert property (go && st_q == smr_pkg::S_IDLE && data_valid_i &&
    cmd_now == `SMR_CH_M |=> ttt_q == 10'h000 && !sr_pend_q)
    else $error("nonzero wait with reading present");
  sr_deadline_a: assert property (sr_pend_q |-> sec_q <= ttt_q)
    else $error("service request overdue");
  std_count_a: assert property (st_q == smr_pkg::S_CNT && !two_q |-> cnt_q <= 4'h9)
    else $error("standard count above nine");
  term_a: assert property (st_q == smr_pkg::S_CR && push |=>
    st_q == smr_pkg::S_LF && bs.valid) else $error("terminator broken");

  ack_c: cover property (st_q == smr_pkg::S_CNT && push ##1 st_q == smr_pkg::S_CR);
  sreq_c: cover property (st_q == smr_pkg::S_IDLE && sr_fire);
  crc_data_c: cover property (st_q == smr_pkg::S_CRC && d_q == 3'h2 && push);
endmodule : smr_responder

// ==== design/smr_consts.svh ====
/*
  Character codes, response maps, value counts and timing figures of the
  measurement responder. Assumes 8-bit ASCII characters on the byte stream.
*/
`ifndef SMR_CONSTS_SVH
`define SMR_CONSTS_SVH
`define SMR_CH_CR 8'h0D
`define SMR_CH_LF 8'h0A
`define SMR_CH_BANG 8'h21
`define SMR_CH_M 8'h4D
`define SMR_CH_C 8'h43
`define SMR_CH_D 8'h44
`define SMR_CH_ZERO 8'h30
`define SMR_CH_NINE 8'h39
`define SMR_CH_PLUS 8'h2B
`define SMR_CH_MINUS 8'h2D
`define SMR_CRC_BASE 8'h40
`define SMR_CRC_POLY 16'hA001
`define SMR_CRC_INIT 16'h0000
`define SMR_SEC_NS 1000000000
`define SMR_CLK_NS 20
`define SMR_TTT_MAX 10'h3E7
// Response maps: count in the top nibble, value slots from the low nibble up
`define SMR_MAP_NONE 24'h000000
`define SMR_MAP_COMB_D0 24'h543210
`define SMR_MAP_COMB_M1 24'h200065
`define SMR_MAP_COMB_M2 24'h300CBA
`define SMR_MAP_COMB_C1 24'h300987
`define SMR_MAP_COMB_C2 24'h10000D
`define SMR_MAP_VEL_D0 24'h40F3E1
`define SMR_MAP_VEL_M1 24'h40DCBA
// Announced value counts
`define SMR_N_NONE 4'h0
`define SMR_N_COMB_M 4'h5
`define SMR_N_COMB_M1 4'h2
`define SMR_N_COMB_M2 4'h3
`define SMR_N_COMB_C 4'h9
`define SMR_N_VEL_M 4'h4
`define SMR_N_VEL_M1 4'h4
`define SMR_N_VEL_C 4'h8
`endif

// ==== design/smr_pkg.sv ====
/*
  Types shared by the measurement responder modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package smr_pkg;
  typedef enum logic [1:0] {
    P_IDLE = 2'b00, P_CMD = 2'b01, P_BODY = 2'b10
  } smr_pstate_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_ADDR = 4'b0001, S_TTT = 4'b0010, S_CNT = 4'b0011,
    S_SIGN = 4'b0100, S_DIG = 4'b0101, S_CRC = 4'b0110, S_CR = 4'b0111,
    S_LF = 4'b1000
  } smr_tstate_t;
  typedef enum logic [2:0] {
    MK_NONE = 3'b000, MK_M0 = 3'b001, MK_M1 = 3'b010, MK_M2 = 3'b011,
    MK_MX = 3'b100, MK_C = 3'b101
  } smr_meas_t;
  typedef enum logic [1:0] {
    J_ADDR = 2'b00, J_ACK = 2'b01, J_SREQ = 2'b10, J_DATA = 2'b11
  } smr_job_t;
endpackage : smr_pkg

// ==== design/smr_byte_if.sv ====
/*
  Byte stream with valid and ready between the responder's own modules.
  Assumes a transfer happens on each rising clock edge with valid and ready high.
*/
`timescale 1ns/1ps
interface smr_byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : smr_byte_if

// ==== design/smr_bin2bcd.sv ====
/*
  Binary to packed BCD converter, purely combinational.
  Assumes the input fits the digit count; higher digits are dropped.
*/
`timescale 1ns/1ps
module smr_bin2bcd #(
  parameter int IN_W = 20,
  parameter int DIGITS = 6
) (
  input wire logic [IN_W-1:0] bin_i,       // Unsigned value
  output logic [4*DIGITS-1:0] bcd_o        // Digits, least significant low
);
  logic [4*DIGITS-1:0] acc;

  ////////////////////////////////////////////////////////////////////////
  // Shift-and-add-three, one pass per input bit
  always_comb begin
    acc = '0;
    for (int i = IN_W - 1; i >= 0; i--) begin
      for (int j = 0; j < DIGITS; j++) begin
        if (acc[4*j +: 4] > 4'h4) begin
          acc[4*j +: 4] = acc[4*j +: 4] + 4'h3;
        end
      end
      acc = {acc[4*DIGITS-2:0], bin_i[i]};
    end
    bcd_o = acc;
  end
endmodule : smr_bin2bcd

// ==== design/smr_skid_buf.sv ====
/*
  Two-entry byte buffer between the response sequencer and the line sender.
  Assumes the sink may hold ready low for any time; outputs are flops.
*/
`timescale 1ns/1ps
module smr_skid_buf #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,                  // System clock
  input wire logic rst_n_i,                // Synchronised reset, low active
  smr_byte_if.snk in_s,                    // Filling side
  output logic out_valid_o,                // Head entry holds a word
  output logic [WIDTH-1:0] out_data_o,     // Head entry
  input wire logic out_ready_i             // Draining side takes the head
);
  logic [WIDTH-1:0] head_q, head_d, tail_q, tail_d;
  logic vld_q, vld_d, full_q, full_d;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////
  // Ready drops only when both entries hold data, so a stall loses nothing
  always_comb begin
    push = in_s.valid & ~full_q;
    pop = vld_q & out_ready_i;
    head_d = head_q;
    tail_d = tail_q;
    vld_d = vld_q;
    full_d = full_q;
    if (pop) begin
      if (full_q) begin
        head_d = tail_q;
        full_d = 1'b0;
      end else begin
        vld_d = push;
        if (push) begin
          head_d = in_s.data;
        end
      end
    end else if (push) begin
      if (vld_q) begin
        tail_d = in_s.data;
        full_d = 1'b1;
      end else begin
        head_d = in_s.data;
        vld_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_q <= '0;
      tail_q <= '0;
      vld_q <= 1'b0;
      full_q <= 1'b0;
    end else begin
      head_q <= head_d;
      tail_q <= tail_d;
      vld_q <= vld_d;
      full_q <= full_d;
    end
  end

  assign in_s.ready = ~full_q;
  assign out_valid_o = vld_q;
  assign out_data_o = head_q;
endmodule : smr_skid_buf

// ==== verification/smr_logger_model.sv ====
/* Datalogger stand-in: sends command characters and collects reply bytes.
   Assumes one design clock; characters go out on falling edges. */
`timescale 1ns/1ps
module smr_logger_model (
  input wire logic clk_i,          // System clock
  input wire logic stall_i,        // High: take a byte every other cycle
  input wire logic tx_valid_i,     // Reply byte offered
  input wire logic [7:0] tx_data_i, // Reply byte
  output logic tx_ready_o,         // Reply byte taken
  output logic rx_valid_o,         // Command character strobe
  output logic [7:0] rx_data_o     // Command character
);
  logic [7:0] got [$];
  logic ph = 1'b0;
  // Stalling halves the drain rate so the buffer fills
  always @(negedge clk_i) begin
    ph <= ~ph;
  end
  assign tx_ready_o = ~stall_i | ph;
  // Collect every byte taken
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
    end
  end
  // Idle data shows the inverse so a stale character is never reused
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk_i);
      rx_valid_o = 1'b1;
      rx_data_o = s[i];
    end
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o;
  endtask : send
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
  end
endmodule : smr_logger_model

// ==== verification/test_smr_responder.sv ====
/* Self-checking bench for the measurement responder.
   Assumes TICK_CYCLES of 10, so one announced second lasts 10 clocks. */
`timescale 1ns/1ps
module test_smr_responder;
  logic clk_sys = 1'b0, rst_n = 1'b0, vel = 1'b0, dval = 1'b0, stall = 1'b0;
  logic rxv, txv, txr;
  logic [7:0] rxd, txd;
  logic [9:0] flen = 10'h003;
  logic [15:0][19:0] vals;
  int val [16];
  int errors = 0, check_count = 0, cyc = 0;
  smr_responder #(.TICK_CYCLES(10)) dut (.clk_sys_i(clk_sys), .rst_n_i(rst_n),
    .rx_valid_i(rxv), .rx_data_i(rxd), .addr_i(8'h30), .velocity_i(vel),
    .data_valid_i(dval), .filter_len_s_i(flen), .vals_i(vals), .tx_ready_i(txr),
    .tx_valid_o(txv), .tx_data_o(txd));
  smr_logger_model dl (.clk_i(clk_sys), .stall_i(stall), .tx_valid_i(txv),
    .tx_data_i(txd), .tx_ready_o(txr), .rx_valid_o(rxv), .rx_data_o(rxd));
  // 50 MHz clock
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // Hang guard, well above the thousand or so cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Expected value text: sign then six digits, slots picked by nibble
  function automatic string body(input logic [23:0] m, input int n);
    string r;
    int v;
    r = "";
    for (int i = 0; i < n; i++) begin
      v = val[m[4*i+:4]];
      r = {r, $sformatf("%s%06d", (v < 0) ? "-" : "+", (v < 0) ? -v : v)};
    end
    return r;
  endfunction : body
  // Reference CRC of a reply text, as three printable characters
  function automatic string crc3(input string s);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < s.len(); i++) begin
      c = c ^ {8'h00, s[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return $sformatf("%c%c%c", 8'h40 | {4'h0, c[15:12]}, 8'h40 | {2'h0, c[11:6]},
                     8'h40 | {2'h0, c[5:0]});
  endfunction : crc3
  // Send a command, then match the reply; ? stands for a CRC character
  task automatic cmd(input string c, input string e, input int n);
    int q;
    string x;
    logic [7:0] exp_b;
    dl.got.delete();
    dl.send(c);
    // An empty expectation waits the full time so a late reply is caught
    for (int t = 0; t < n && (dl.got.size() < e.len() || e.len() == 0); t++) begin
      @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    q = 0;
    while (q < e.len() && e[q] != "?") begin
      q++;
    end
    x = crc3(e.substr(0, q - 1));
    check_count++;
    if (dl.got.size() != e.len()) begin
      $display("MISMATCH %s length expected %0d seen %0d", c, e.len(), dl.got.size());
      errors++;
    end
    for (int i = 0; i < e.len() && i < dl.got.size(); i++) begin
      exp_b = (e[i] == "?") ? x[i - q] : e[i];
      check_count++;
      if (dl.got[i] !== exp_b) begin
        $display("MISMATCH %s byte %0d expected %h seen %h", c, i, exp_b, dl.got[i]);
        errors++;
      end
    end
  endtask : cmd
  ////////////////////////////////////////////////////////////////////////
  task automatic t_power_up();
    cmd("0MC!", "00035\r\n", 60);
    cmd("", "0\r\n", 50);
    cmd("0D0!", {"0", body(24'h43210, 5), "???\r\n"}, 120);
    cmd("0D9!", "0???\r\n", 60);
  endtask : t_power_up
  task automatic t_ready_stalled();
    dval = 1'b1;
    stall = 1'b1;
    cmd("0M!", "00005\r\n", 60);
    cmd("", "", 60);
    cmd("0D0!", {"0", body(24'h43210, 5), "\r\n"}, 200);
    cmd("0M1!", "00002\r\n", 60);
    cmd("0D0!", {"0", body(24'h65, 2), "\r\n"}, 120);
    cmd("0M2!", "00003\r\n", 60);
    cmd("0D0!", {"0", body(24'hCBA, 3), "\r\n"}, 120);
    cmd("0M3!", "00000\r\n", 60);
    cmd("0!", "0\r\n", 30);
    cmd("1M!", "", 30);
    stall = 1'b0;
  endtask : t_ready_stalled
  task automatic t_concurrent();
    cmd("0CC!", "000009\r\n", 60);
    cmd("0D1!", {"0", body(24'h987, 3), "???\r\n"}, 120);
    cmd("0D2!", {"0", body(24'hD, 1), "???\r\n"}, 120);
    cmd("0D3!", "0???\r\n", 60);
  endtask : t_concurrent
  task automatic t_velocity();
    vel = 1'b1;
    cmd("0M!", "00004\r\n", 60);
    cmd("0D0!", {"0", body(24'hF3E1, 4), "\r\n"}, 120);
    cmd("0M1!", "00004\r\n", 60);
    cmd("0D0!", {"0", body(24'hDCBA, 4), "\r\n"}, 120);
    cmd("0M2!", "00000\r\n", 60);
    dval = 1'b0;
    cmd("0C!", "000308\r\n", 60);
    cmd("", "", 60);
    cmd("0M!", "00034\r\n", 60);
    // A reading arriving early must bring the request well before the deadline
    dval = 1'b1;
    cmd("", "0\r\n", 6);
  endtask : t_velocity
  task automatic results();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  // Main sequence, inputs change on falling edges
  initial begin
    for (int i = 0; i < 16; i++) begin
      val[i] = i * 1111 + 5;
    end
    val[1] = -24680;
    for (int i = 0; i < 16; i++) begin
      vals[i] = val[i][19:0];
    end
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_power_up();
    t_ready_stalled();
    t_concurrent();
    t_velocity();
    results();
  end
endmodule : test_smr_responder
